//--- logic/sse_spi_ss_events.sv
// Summary of operation
// - slave role: select pin is always input
// - master, fault check on: pin watched for fault
// - fault check off: output enable decides pin
// - auto select: master drives select during transfers
// - auto select held high when idle
// - both off: pin released to general I/O
// - master shifts out and in together
// - two shift registers swap contents per transfer
// - done flag on transfer or data copy
// - fault flag on low select in fault mode
// - overrun flag on receive overrun
// - shared request when flag set and enabled
// - flags stay set until software clears
`timescale 1ns/1ps
`default_nettype none
module sse_spi_ss_events (
   input  wire logic               REF_CLK_I,      // system clock
   input  wire logic               RST_I,          // async reset, high
   input  wire logic               CE_I,           // clock enable
   input  wire sse_pkg::sse_cfg_t  CFG_I,          // role and select config
   input  wire logic               SPI_IRQ_EN_I,   // serial port irq enable
   input  wire logic               GLOBAL_IRQ_EN_I, // global irq enable
   input  wire logic [7:0]         TX_DATA_I,      // byte to send
   input  wire logic               TX_WRITE_I,     // data write strobe
   input  wire logic               FLAG_WRITE_I,   // flag write strobe
   input  wire logic [2:0]         FLAG_WDATA_I,   // zero bits clear flags
   output logic [7:0]              RX_DATA_O,      // received byte
   output sse_pkg::sse_flags_t     FLAGS_O,        // status flags
   output logic                    IRQ_O,          // shared request
   output logic                    BUSY_O,         // master transfer running
   input  wire logic               SCK_LINK_I,     // serial clock in, slave
   output logic                    SCK_O,          // serial clock out
   output logic                    SCK_OE_N_O,     // clock drive enable, low
   input  wire logic               MOSI_I,         // master-out line in
   output logic                    MOSI_O,         // master-out line out
   output logic                    MOSI_OE_N_O,    // master-out enable, low
   input  wire logic               MISO_I,         // master-in line in
   output logic                    MISO_O,         // master-in line out
   output logic                    MISO_OE_N_O,    // master-in enable, low
   input  wire logic               SS_N_I,         // select pin in
   output logic                    SS_N_O,         // select pin out
   output logic                    SS_N_OE_N_O,    // select enable, low
   output logic                    SS_GPIO_O       // pin given to port I/O
);

////////////////////////////////////////////////////////////////////////////////
   logic [1:0]           ss_sync;
   logic [1:0]           miso_sync;
   logic [2:0]           tgl_sync;
   logic                 ss_s;
   logic                 miso_s;
   logic                 slave_new;
   logic                 l_tgl;
   logic [7:0]           l_buf;
   logic [7:0]           l_sr;
   logic [2:0]           l_cnt;

   always_ff @(posedge REF_CLK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         ss_sync   <= sse_pkg::SYNC2_RST_HI;
         miso_sync <= sse_pkg::SYNC2_RST_LO;
         tgl_sync  <= sse_pkg::SYNC3_RST;
      end
      else if (CE_I)
      begin
         ss_sync   <= {ss_sync[0], SS_N_I};
         miso_sync <= {miso_sync[0], MISO_I};
         tgl_sync  <= {tgl_sync[1:0], l_tgl};
      end
   end

   assign ss_s      = ss_sync[1];
   assign miso_s    = miso_sync[1];
   assign slave_new = tgl_sync[2] ^ tgl_sync[1];

////////////////////////////////////////////////////////////////////////////////
   sse_pkg::sse_ss_use_t ss_use;
   sse_pkg::sse_ss_use_t next_ss_use;
   logic                 role_master;
   logic                 fault_evt;

   always_comb
   begin
      if (!CFG_I.master)
         next_ss_use = sse_pkg::SS_SLAVE_IN;
      else if (!CFG_I.mode_fault_disable)
         next_ss_use = sse_pkg::SS_FAULT_IN;
      else if (CFG_I.ss_output_enable)
         next_ss_use = sse_pkg::SS_AUTO_OUT;
      else
         next_ss_use = sse_pkg::SS_GPIO;
   end

   always_ff @(posedge REF_CLK_I or posedge RST_I)
   begin
      if (RST_I)
         ss_use <= sse_pkg::SS_SLAVE_IN;
      else if (CE_I)
         ss_use <= next_ss_use;
   end

   assign role_master = (ss_use != sse_pkg::SS_SLAVE_IN);
   assign fault_evt   = (ss_use == sse_pkg::SS_FAULT_IN) && !ss_s;

////////////////////////////////////////////////////////////////////////////////
   sse_pkg::sse_mstate_t m_state;
   sse_pkg::sse_mstate_t next_m_state;
   logic [1:0]           m_half;
   logic [1:0]           next_m_half;
   logic [2:0]           m_cnt;
   logic [2:0]           next_m_cnt;
   logic [7:0]           m_sr;
   logic [7:0]           next_m_sr;
   logic                 sck;
   logic                 next_sck;
   logic                 ss_n;
   logic                 next_ss_n;
   logic [7:0]           tx_hold;
   logic [7:0]           next_tx_hold;
   logic                 m_done;
   sse_pkg::sse_flags_t  flags;

   always_comb
   begin
      next_m_state = m_state;
      next_m_half  = m_half;
      next_m_cnt   = m_cnt;
      next_m_sr    = m_sr;
      next_sck     = sck;
      next_tx_hold = tx_hold;
      m_done       = 1'b0;
      if (TX_WRITE_I && !role_master)
         next_tx_hold = TX_DATA_I;
      case (m_state)
         sse_pkg::MS_IDLE:
         begin
            next_sck = 1'b0;
            if (TX_WRITE_I && role_master && !flags.mode_fault && !fault_evt)
            begin
               next_m_sr    = TX_DATA_I;
               next_m_cnt   = sse_pkg::BIT_RST;
               next_m_half  = sse_pkg::HALF_RST;
               next_m_state = sse_pkg::MS_LOW;
            end
         end
         sse_pkg::MS_LOW:
         begin
            if (fault_evt)
               next_m_state = sse_pkg::MS_IDLE;
            else if (m_half == sse_pkg::HALF_LAST)
            begin
               next_m_half  = sse_pkg::HALF_RST;
               next_sck     = 1'b1;
               next_m_state = sse_pkg::MS_HIGH;
            end
            else
               next_m_half = m_half + 2'h1;
         end
         sse_pkg::MS_HIGH:
         begin
            if (fault_evt)
            begin
               next_sck     = 1'b0;
               next_m_state = sse_pkg::MS_IDLE;
            end
            else if (m_half == sse_pkg::HALF_LAST)
            begin
               next_m_half = sse_pkg::HALF_RST;
               next_sck    = 1'b0;
               next_m_sr   = {m_sr[6:0], miso_s};
               if (m_cnt == sse_pkg::BIT_LAST)
               begin
                  m_done       = 1'b1;
                  next_m_state = sse_pkg::MS_IDLE;
               end
               else
               begin
                  next_m_cnt   = m_cnt + 3'h1;
                  next_m_state = sse_pkg::MS_LOW;
               end
            end
            else
               next_m_half = m_half + 2'h1;
         end
         default:
            next_m_state = sse_pkg::MS_IDLE;
      endcase
      next_ss_n = (next_m_state == sse_pkg::MS_IDLE);
   end

   always_ff @(posedge REF_CLK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         m_state <= sse_pkg::MS_IDLE;
         m_half  <= sse_pkg::HALF_RST;
         m_cnt   <= sse_pkg::BIT_RST;
         m_sr    <= sse_pkg::DATA_RST;
         sck     <= 1'b0;
         ss_n    <= 1'b1;
         tx_hold <= sse_pkg::DATA_RST;
      end
      else if (CE_I)
      begin
         m_state <= next_m_state;
         m_half  <= next_m_half;
         m_cnt   <= next_m_cnt;
         m_sr    <= next_m_sr;
         sck     <= next_sck;
         ss_n    <= next_ss_n;
         tx_hold <= next_tx_hold;
      end
   end

////////////////////////////////////////////////////////////////////////////////
   sse_pkg::sse_flags_t  next_flags;
   logic [7:0]           rx;
   logic [7:0]           next_rx;
   logic                 rx_new;
   logic                 ovr_evt;
   logic [2:0]           clr;

   always_comb
   begin
      rx_new  = m_done | slave_new;
      ovr_evt = rx_new && flags.done;
      clr     = FLAG_WRITE_I ? ~FLAG_WDATA_I : 3'h0;
      next_flags = sse_pkg::sse_flags_t'((flags & ~clr) | {ovr_evt, fault_evt, rx_new});
      next_rx = rx;
      if (rx_new && !flags.done)
         next_rx = m_done ? next_m_sr : l_buf;
   end

   always_ff @(posedge REF_CLK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         flags <= sse_pkg::sse_flags_t'(sse_pkg::FLAGS_RST);
         rx    <= sse_pkg::DATA_RST;
      end
      else if (CE_I)
      begin
         flags <= next_flags;
         rx    <= next_rx;
      end
   end

////////////////////////////////////////////////////////////////////////////////
   // slave shifting on the partner's clock; frame ends when select rises
   logic                 link_rst;
   logic [7:0]           l_shift;
   logic [2:0]           next_l_cnt;

   assign link_rst = RST_I | SS_N_I | role_master;

   always_comb
   begin
      l_shift    = {((l_cnt == sse_pkg::BIT_RST) ? tx_hold[6:0] : l_sr[6:0]), MOSI_I};
      next_l_cnt = l_cnt + 3'h1;
   end

   always_ff @(posedge SCK_LINK_I or posedge link_rst)
   begin
      if (link_rst)
      begin
         l_sr  <= sse_pkg::DATA_RST;
         l_cnt <= sse_pkg::BIT_RST;
      end
      else
      begin
         l_sr  <= l_shift;
         l_cnt <= next_l_cnt;
      end
   end

   always_ff @(posedge SCK_LINK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         l_buf <= sse_pkg::DATA_RST;
         l_tgl <= 1'b0;
      end
      else if (!link_rst && l_cnt == sse_pkg::BIT_LAST)
      begin
         l_buf <= l_shift;
         l_tgl <= ~l_tgl;
      end
   end

////////////////////////////////////////////////////////////////////////////////
   assign RX_DATA_O   = rx;
   assign FLAGS_O     = flags;
   assign IRQ_O       = (|flags) && SPI_IRQ_EN_I && GLOBAL_IRQ_EN_I;
   assign BUSY_O      = (m_state != sse_pkg::MS_IDLE);
   assign SCK_O       = sck;
   assign SCK_OE_N_O  = !(role_master && !flags.mode_fault);
   assign MOSI_O      = m_sr[7];
   assign MOSI_OE_N_O = !(role_master && !flags.mode_fault);
   assign MISO_O      = (l_cnt == sse_pkg::BIT_RST) ? tx_hold[7] : l_sr[7];
   assign MISO_OE_N_O = !((ss_use == sse_pkg::SS_SLAVE_IN) && !SS_N_I);
   assign SS_N_O      = ss_n;
   assign SS_N_OE_N_O = (ss_use != sse_pkg::SS_AUTO_OUT);
   assign SS_GPIO_O   = (ss_use == sse_pkg::SS_GPIO);

////////////////////////////////////////////////////////////////////////////////
   property p_slave_in;
      @(posedge REF_CLK_I) disable iff (RST_I)
      (CE_I && !CFG_I.master) |=> (SS_N_OE_N_O && !SS_GPIO_O);
   endproperty
   a_slave_in: assert property (p_slave_in) else $error("select not input in slave role");

   property p_fault_watch;
      @(posedge REF_CLK_I) disable iff (RST_I)
      (CE_I && ss_use == sse_pkg::SS_FAULT_IN && !ss_s) |=> FLAGS_O.mode_fault;
   endproperty
   a_fault_watch: assert property (p_fault_watch) else $error("mode fault missed");

   property p_fault_off;
      @(posedge REF_CLK_I) disable iff (RST_I)
      $rose(FLAGS_O.mode_fault) |-> ($past(ss_use) == sse_pkg::SS_FAULT_IN);
   endproperty
   a_fault_off: assert property (p_fault_off) else $error("fault flagged with detection off");

   property p_auto_sel;
      @(posedge REF_CLK_I) disable iff (RST_I)
      (ss_use == sse_pkg::SS_AUTO_OUT && m_state != sse_pkg::MS_IDLE) |-> (!SS_N_O && !SS_N_OE_N_O);
   endproperty
   a_auto_sel: assert property (p_auto_sel) else $error("auto select not low in transfer");

   property p_idle_high;
      @(posedge REF_CLK_I) disable iff (RST_I)
      (m_state == sse_pkg::MS_IDLE) ##1 (m_state == sse_pkg::MS_IDLE) |-> SS_N_O;
   endproperty
   a_idle_high: assert property (p_idle_high) else $error("select low while idle");

   property p_gpio;
      @(posedge REF_CLK_I) disable iff (RST_I)
      (CE_I && CFG_I.master && CFG_I.mode_fault_disable && !CFG_I.ss_output_enable)
         |=> (SS_GPIO_O && SS_N_OE_N_O);
   endproperty
   a_gpio: assert property (p_gpio) else $error("select pin not released");

   property p_shift_in;
      @(posedge REF_CLK_I) disable iff (RST_I)
      (CE_I && m_state == sse_pkg::MS_HIGH && m_half == sse_pkg::HALF_LAST && !fault_evt)
         |=> (m_sr[0] == $past(miso_s) && !SCK_O);
   endproperty
   a_shift_in: assert property (p_shift_in) else $error("master did not sample input");

   property p_load;
      @(posedge REF_CLK_I) disable iff (RST_I)
      (CE_I && m_state == sse_pkg::MS_IDLE && TX_WRITE_I && role_master && !flags.mode_fault && !fault_evt)
         |=> (m_sr == $past(TX_DATA_I) && m_state == sse_pkg::MS_LOW);
   endproperty
   a_load: assert property (p_load) else $error("transfer did not load byte");

   property p_done;
      @(posedge REF_CLK_I) disable iff (RST_I)
      (CE_I && rx_new) |=> FLAGS_O.done;
   endproperty
   a_done: assert property (p_done) else $error("done flag not set");

   property p_ovr;
      @(posedge REF_CLK_I) disable iff (RST_I)
      (CE_I && rx_new && FLAGS_O.done) |=> (FLAGS_O.overrun && $stable(RX_DATA_O));
   endproperty
   a_ovr: assert property (p_ovr) else $error("overrun not flagged");

   property p_irq;
      @(posedge REF_CLK_I) disable iff (RST_I)
      IRQ_O |-> ((FLAGS_O.done || FLAGS_O.mode_fault || FLAGS_O.overrun) && SPI_IRQ_EN_I && GLOBAL_IRQ_EN_I);
   endproperty
   a_irq: assert property (p_irq) else $error("request without enabled flag");

   property p_hold;
      @(posedge REF_CLK_I) disable iff (RST_I)
      (FLAGS_O.done && !(CE_I && FLAG_WRITE_I && !FLAG_WDATA_I[sse_pkg::FLAG_DONE_POS])) |=> FLAGS_O.done;
   endproperty
   a_hold: assert property (p_hold) else $error("done flag cleared by itself");

   property p_set_wins;
      @(posedge REF_CLK_I) disable iff (RST_I)
      (CE_I && fault_evt && FLAG_WRITE_I && !FLAG_WDATA_I[sse_pkg::FLAG_FAULT_POS]) |=> FLAGS_O.mode_fault;
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("clear beat a set");

endmodule // sse_spi_ss_events
`default_nettype wire

//--- shared/sse_pkg.sv
`default_nettype none
package sse_pkg;

   // serial clock half period in system clocks, minus one
   localparam logic [1:0] HALF_LAST = 2'h3;
   localparam logic [1:0] HALF_RST  = 2'h0;
   // last bit index of a byte
   localparam logic [2:0] BIT_LAST  = 3'h7;
   localparam logic [2:0] BIT_RST   = 3'h0;
   localparam logic [7:0] DATA_RST  = 8'h00;
   // flag positions in the flag write word
   localparam int unsigned FLAG_DONE_POS  = 0;
   localparam int unsigned FLAG_FAULT_POS = 1;
   localparam int unsigned FLAG_OVR_POS   = 2;
   localparam logic [2:0] FLAGS_RST = 3'h0;
   localparam logic [1:0] SYNC2_RST_HI = 2'h3;
   localparam logic [1:0] SYNC2_RST_LO = 2'h0;
   localparam logic [2:0] SYNC3_RST    = 3'h0;

   typedef struct packed {
      logic overrun;
      logic mode_fault;
      logic done;
   } sse_flags_t;

   typedef struct packed {
      logic master;
      logic mode_fault_disable;
      logic ss_output_enable;
   } sse_cfg_t;

   typedef enum logic [1:0] {
      SS_SLAVE_IN,
      SS_FAULT_IN,
      SS_AUTO_OUT,
      SS_GPIO
   } sse_ss_use_t;

   typedef enum logic [1:0] {
      MS_IDLE,
      MS_LOW,
      MS_HIGH
   } sse_mstate_t;

endpackage
`default_nettype wire

//--- dv/sse_far_dev.sv
`timescale 1ns/1ps
`default_nettype none
module sse_far_dev (
   input  wire logic sck_m,  // serial clock wire
   input  wire logic ss_m_n, // select wire, low selects
   input  wire logic mosi_m, // master-out wire
   output logic      miso_s, // master-in drive
   output logic      sck_l,  // serial clock drive
   output logic      ss_l_n, // select drive, high when released
   output logic      mosi_l, // master-out drive
   input  wire logic miso_l  // master-in wire
);
   logic [7:0] s_tx;
   logic [7:0] s_sh;
   logic [7:0] m_rx;
   logic       in_bit;
   logic       last_miso;

   initial
   begin
      s_tx = 8'h00;
      s_sh = 8'h00;
      m_rx = 8'h00;
      in_bit = 1'b0;
      last_miso = 1'b0;
      sck_l = 1'b0;
      ss_l_n = 1'b1;
      mosi_l = 1'b0;
   end

   ////////////////////////////////////////////////////////////
   // slave side exchange
   always @(negedge ss_m_n) s_sh = s_tx;
   always @(posedge sck_m) in_bit = mosi_m;
   always @(negedge sck_m) s_sh = {s_sh[6:0], in_bit};
   always @(posedge ss_m_n) last_miso = s_sh[7];
   // released line shows the inverse of its last bit
   always @*
   begin
      if (!ss_m_n)
         miso_s = s_sh[7];
      else
         miso_s = ~last_miso;
   end

   ////////////////////////////////////////////////////////////
   // own select line
   task automatic set_sel(input logic v);
      ss_l_n = v;
   endtask

   // master side exchange, clock only in frame
   task automatic xfer(input logic [7:0] b);
      integer i;
      ss_l_n = 1'b0;
      for (i = 7; i >= 0; i--)
      begin
         mosi_l = b[i];
         #7.5;
         m_rx = {m_rx[6:0], miso_l};
         sck_l = 1'b1;
         #7.5;
         sck_l = 1'b0;
      end
      #7.5;
      mosi_l = ~mosi_l;
      ss_l_n = 1'b1;
   endtask
endmodule // sse_far_dev
`default_nettype wire

//--- dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic                ref_clk;
   logic                rst;
   logic                ce;
   sse_pkg::sse_cfg_t   cfg;
   logic                spi_irq_en;
   logic                glb_irq_en;
   logic [7:0]          tx_data;
   logic                tx_write;
   logic                flag_write;
   logic [2:0]          flag_wdata;
   logic [7:0]          rx_data;
   sse_pkg::sse_flags_t flags;
   logic                irq, busy, sck, sck_oe_n, mosi_o, mosi_oe_n;
   logic                miso_o, miso_oe_n, ss_o, ss_oe_n, ss_gpio;
   logic                sck_l, mosi_l, miso_s, ss_l_n;
   wire logic           sck_w, mosi_w, miso_w, ss_w;
   int                  n_fail;
   int                  cmp_count;
   int                  i;

   // each line is driven by whichever party has it enabled
   assign sck_w  = sck_oe_n ? sck_l : sck;
   assign mosi_w = mosi_oe_n ? mosi_l : mosi_o;
   assign miso_w = miso_oe_n ? miso_s : miso_o;
   assign ss_w   = ss_oe_n ? ss_l_n : ss_o;

   always #10 ref_clk = ~ref_clk;

   sse_spi_ss_events dut (
      .REF_CLK_I(ref_clk), .RST_I(rst), .CE_I(ce), .CFG_I(cfg),
      .SPI_IRQ_EN_I(spi_irq_en), .GLOBAL_IRQ_EN_I(glb_irq_en),
      .TX_DATA_I(tx_data), .TX_WRITE_I(tx_write),
      .FLAG_WRITE_I(flag_write), .FLAG_WDATA_I(flag_wdata),
      .RX_DATA_O(rx_data), .FLAGS_O(flags), .IRQ_O(irq), .BUSY_O(busy),
      .SCK_LINK_I(sck_w), .SCK_O(sck), .SCK_OE_N_O(sck_oe_n),
      .MOSI_I(mosi_w), .MOSI_O(mosi_o), .MOSI_OE_N_O(mosi_oe_n),
      .MISO_I(miso_w), .MISO_O(miso_o), .MISO_OE_N_O(miso_oe_n),
      .SS_N_I(ss_w), .SS_N_O(ss_o), .SS_N_OE_N_O(ss_oe_n), .SS_GPIO_O(ss_gpio)
   );

   sse_far_dev far (
      .sck_m(sck_w), .ss_m_n(ss_w), .mosi_m(mosi_w), .miso_s(miso_s),
      .sck_l(sck_l), .ss_l_n(ss_l_n), .mosi_l(mosi_l), .miso_l(miso_w)
   );

   ////////////////////////////////////////////////////////////
   task automatic chk_b(input string name, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic chk_f(input string name, input logic exp, input logic got);
      cmp_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[ERR] %s expected %b seen %b", name, exp, got);
      end
   endtask

   task automatic pulse_tx(input logic [7:0] b);
      @(posedge ref_clk);
      tx_data <= b;
      tx_write <= 1'b1;
      @(posedge ref_clk);
      tx_write <= 1'b0;
   endtask

   task automatic clr_flags(input logic [2:0] w);
      @(posedge ref_clk);
      flag_write <= 1'b1;
      flag_wdata <= w;
      @(posedge ref_clk);
      flag_write <= 1'b0;
      flag_wdata <= 3'h7;
   endtask

   task automatic close_out;
      if (n_fail == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////
   initial
   begin
      repeat (3000) @(posedge ref_clk);
      n_fail++;
      close_out();
   end

   initial
   begin
      ref_clk = 1'b0;
      rst = 1'b1;
      ce = 1'b1;
      cfg = sse_pkg::sse_cfg_t'(3'h0);
      spi_irq_en = 1'b0;
      glb_irq_en = 1'b0;
      tx_data = 8'h00;
      tx_write = 1'b0;
      flag_write = 1'b0;
      flag_wdata = 3'h7;
      n_fail = 0;
      cmp_count = 0;
      repeat (16) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (2) @(posedge ref_clk);
      #1 chk_f("ss_oe_n", 1'b1, ss_oe_n);
      chk_f("ss_gpio", 1'b0, ss_gpio);
      // slave role exchange
      pulse_tx(8'h3C);
      repeat (4) @(posedge ref_clk);
      #3 far.xfer(8'hA5);
      repeat (10) @(posedge ref_clk);
      #1 chk_b("rx_data", 8'hA5, rx_data);
      chk_b("far_rx", 8'h3C, far.m_rx);
      chk_f("done", 1'b1, flags.done);
      chk_f("overrun", 1'b0, flags.overrun);
      for (i = 0; i < 4; i++)
      begin
         @(posedge ref_clk);
         spi_irq_en <= i[0];
         glb_irq_en <= i[1];
         @(posedge ref_clk);
         #1 chk_f("irq", i == 3, irq);
      end
      // second byte while done still set
      far.xfer(8'h11);
      repeat (30) @(posedge ref_clk);
      #1 chk_f("overrun", 1'b1, flags.overrun);
      chk_b("rx_kept", 8'hA5, rx_data);
      chk_f("done_held", 1'b1, flags.done);
      clr_flags(3'h6);
      #1 chk_b("flags_mfc", 8'h04, {5'h00, flags});
      clr_flags(3'h0);
      #1 chk_b("flags_clr", 8'h00, {5'h00, flags});
      chk_f("irq_idle", 1'b0, irq);
      // master with automatic select
      @(posedge ref_clk);
      cfg <= sse_pkg::sse_cfg_t'(3'h7);
      far.s_tx = 8'h5A;
      repeat (3) @(posedge ref_clk);
      #1 chk_f("ss_oe_n", 1'b0, ss_oe_n);
      chk_f("ss_idle", 1'b1, ss_o);
      pulse_tx(8'h96);
      @(posedge ref_clk);
      #1 chk_f("busy", 1'b1, busy);
      chk_f("ss_sel", 1'b0, ss_o);
      // clear is sampled on the edge that sets done
      repeat (62) @(posedge ref_clk);
      flag_write <= 1'b1;
      flag_wdata <= 3'h0;
      @(posedge ref_clk);
      flag_write <= 1'b0;
      flag_wdata <= 3'h7;
      #1 chk_f("done_set_wins", 1'b1, flags.done);
      chk_f("busy_end", 1'b0, busy);
      chk_f("ss_after", 1'b1, ss_o);
      chk_b("rx_master", 8'h5A, rx_data);
      chk_b("far_slave_rx", 8'h96, far.s_sh);
      clr_flags(3'h0);
      // select released to port I/O
      @(posedge ref_clk);
      cfg <= sse_pkg::sse_cfg_t'(3'h6);
      repeat (3) @(posedge ref_clk);
      #1 chk_f("ss_gpio", 1'b1, ss_gpio);
      chk_f("ss_oe_n", 1'b1, ss_oe_n);
      far.set_sel(1'b0);
      repeat (8) @(posedge ref_clk);
      #1 chk_f("no_fault", 1'b0, flags.mode_fault);
      far.set_sel(1'b1);
      // fault watch
      @(posedge ref_clk);
      cfg <= sse_pkg::sse_cfg_t'(3'h4);
      repeat (3) @(posedge ref_clk);
      #1 chk_f("ss_gpio", 1'b0, ss_gpio);
      chk_f("ss_oe_n", 1'b1, ss_oe_n);
      far.set_sel(1'b0);
      repeat (6) @(posedge ref_clk);
      #1 chk_f("fault", 1'b1, flags.mode_fault);
      chk_f("sck_oe_n", 1'b1, sck_oe_n);
      pulse_tx(8'hF0);
      repeat (2) @(posedge ref_clk);
      #1 chk_f("busy_refused", 1'b0, busy);
      // clear against a live fault, select still low
      clr_flags(3'h5);
      #1 chk_f("fault_set_wins", 1'b1, flags.mode_fault);
      far.set_sel(1'b1);
      repeat (4) @(posedge ref_clk);
      // clock enable low freezes the flags
      ce <= 1'b0;
      clr_flags(3'h5);
      #1 chk_f("fault_frozen", 1'b1, flags.mode_fault);
      ce <= 1'b1;
      clr_flags(3'h5);
      #1 chk_f("fault_clr", 1'b0, flags.mode_fault);
      close_out();
   end
endmodule // tb_top
`default_nettype wire
